// file: hw/oer_pkg.sv
// shared constants for the octal edge register
package oer_pkg;
	localparam int OER_BITS = 8;
	localparam int OER_SYNC_STAGES = 3;
	localparam logic OER_OE_RESET = 1'h0;
	localparam logic OER_LEVEL_RESET = 1'h0;
	localparam logic OER_ENABLE_N_RESET = 1'h1;
	localparam logic OER_VALID_RESET = 1'h0;
endpackage : oer_pkg

// file: hw/oer_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module oer_pin_sync
	import oer_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// pin side
	input wire logic [W-1:0] pin,
	// clock-domain side
	output logic [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] level;
	} oer_sync_s;

	oer_sync_s r;
	oer_sync_s next_r;

	always_comb begin
		next_r = r;
		next_r.s1 = pin;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		// a bit only moves once stages two and three agree, masking metastable glitches
		for (int i = 0; i < W; i++) begin
			if (r.s2[i] == r.s3[i]) begin
				next_r.level[i] = r.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= {INIT, INIT, INIT, INIT};
		end else begin
			r <= next_r;
		end
	end

	assign level = r.level;
endmodule : oer_pin_sync

// file: hw/oer_octal_reg.sv
// eight-bit edge register with shared clock pin and three-state outputs
`timescale 1ns/1ps
module oer_octal_reg
	import oer_pkg::*;
#(
	parameter int BITS = OER_BITS
) (
	// system clock and reset
	input wire logic clk,
	input wire logic reset,
	// register clock and enable pins
	input wire logic reg_clk_pin,
	input wire logic out_enable_n,
	// data input pins and whether each is actively driven
	input wire logic [BITS-1:0] data_in,
	input wire logic [BITS-1:0] data_in_driven,
	// three-state outputs
	output logic [BITS-1:0] data_out,
	output logic [BITS-1:0] data_out_oe,
	// status
	output logic contents_valid
);
	typedef struct packed {
		logic clk_prev;
		logic [BITS-1:0] previous_level;
		logic [BITS-1:0] store;
		logic valid;
		logic [BITS-1:0] out;
		logic [BITS-1:0] oe;
	} oer_s;

	oer_s r;
	oer_s next_r;
	logic clk_level;
	logic enable_n_level;
	logic [BITS-1:0] data_level;
	logic [BITS-1:0] driven_level;
	logic [BITS-1:0] held;
	logic clk_rise;

	oer_pin_sync #(.W(1), .INIT(OER_LEVEL_RESET)) u_clk_sync (
		.clk(clk),
		.reset(reset),
		.pin(reg_clk_pin),
		.level(clk_level)
	);

	oer_pin_sync #(.W(1), .INIT(OER_ENABLE_N_RESET)) u_oe_sync (
		.clk(clk),
		.reset(reset),
		.pin(out_enable_n),
		.level(enable_n_level)
	);

	oer_pin_sync #(.W(2 * BITS), .INIT('0)) u_data_sync (
		.clk(clk),
		.reset(reset),
		.pin({data_in_driven, data_in}),
		.level({driven_level, data_level})
	);

	always_comb begin
		next_r = r;
		clk_rise = clk_level & ~r.clk_prev;
		next_r.clk_prev = clk_level;
		// bus hold: a floating input keeps its last valid level
		for (int i = 0; i < BITS; i++) begin
			held[i] = driven_level[i] ? data_level[i] : r.previous_level[i];
		end
		next_r.previous_level = held;
		// capture runs regardless of the enable
		if (clk_rise) begin
			next_r.store = held;
			next_r.valid = 1'h1;
		end
		next_r.out = next_r.store;
		next_r.oe = {BITS{~enable_n_level}};
	end

	// stored bits take no reset on purpose: their power-up value is undefined
	always_ff @(posedge clk) begin
		if (reset) begin
			r.clk_prev <= OER_LEVEL_RESET;
			r.previous_level <= '0;
			r.valid <= OER_VALID_RESET;
			r.oe <= {BITS{OER_OE_RESET}};
			r.store <= next_r.store;
			r.out <= next_r.out;
		end else begin
			r <= next_r;
		end
	end

	assign data_out = r.out;
	assign data_out_oe = r.oe;
	assign contents_valid = r.valid;
endmodule : oer_octal_reg

// file: sim/oer_octal_reg_monitor.sv
// port checks for the octal edge register
`timescale 1ns/1ps
module oer_octal_reg_monitor (
	// watched ports
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_clk_pin,
	input wire logic out_enable_n,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_in_driven,
	input wire logic [7:0] data_out,
	input wire logic [7:0] data_out_oe,
	input wire logic contents_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence cap_s;
		($stable(data_in) && &data_in_driven)[*5] ##0 $rose(reg_clk_pin) ##1 ($stable(data_in) && reg_clk_pin)[*5];
	endsequence
	oe_track_a: assert property ($stable(out_enable_n)[*7] |-> data_out_oe == {8{!out_enable_n}}) else $error("oe");
	load_data_a: assert property (cap_s |-> contents_valid && data_out == data_in) else $error("load");
	hold_data_a: assert property ($stable(reg_clk_pin)[*8] ##0 contents_valid |-> $stable(data_out))
		else $error("drift");
	valid_keep_a: assert property (contents_valid |=> contents_valid) else $error("valid");
	valid_first_a: assert property ($rose(contents_valid) |-> $past(reg_clk_pin, 5) && !$past(reg_clk_pin, 6))
		else $error("first load");
	reset_float_a: assert property (disable iff (1'b0) reset |=> data_out_oe == 8'h00 && !contents_valid)
		else $error("reset float");
endmodule : oer_octal_reg_monitor
bind oer_octal_reg oer_octal_reg_monitor i_mon (.*);

// file: sim/oer_bus_model.sv
// far-side bus line, toggling while released
`timescale 1ns/1ps
module oer_bus_model (
	// register outputs and bus line
	input wire logic clk,
	input wire logic [7:0] data_out,
	input wire logic [7:0] data_out_oe,
	output logic [7:0] bus
);
	always_ff @(posedge clk) bus <= data_out_oe[0] ? data_out : ~bus;
endmodule : oer_bus_model

// file: sim/tb_oer_octal_reg.sv
// bench for the octal edge register
`timescale 1ns/1ps
module tb_oer_octal_reg;
	logic clk = 0, reset = 1, reg_clk_pin = 0, out_enable_n = 0, contents_valid;
	logic [7:0] data_in = 0, data_in_driven = 0, data_out, data_out_oe, bus;
	int fail_count = 0, tests_run = 0;
	always #5 clk = ~clk;
	oer_octal_reg i_oer_octal_reg (.*);
	oer_bus_model i_oer_bus_model (.*);
	task automatic chk(logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) $display("[FAIL] %0t %h", $time, seen);
		fail_count += int'(seen !== exp);
	endtask : chk
	task automatic load(logic [7:0] d, drv);
		data_in <= d;
		data_in_driven <= drv;
		repeat (6) @(posedge clk);
		reg_clk_pin <= 1;
		repeat (6) @(posedge clk);
		reg_clk_pin <= 0;
	endtask : load
	task automatic s_all();
		load(8'hA5, 8'hFF);
		chk(data_out, 8'hA5);
		chk({7'h00, contents_valid}, 8'h01);
		chk(data_out_oe, 8'hFF);
		load(8'h96, 8'hFF);
		// floating upper bits keep their last driven level
		load(8'h69, 8'h0F);
		chk(data_out, 8'h99);
		out_enable_n <= 1;
		load(8'h3C, 8'hFF);
		chk(data_out_oe, 8'h00);
		out_enable_n <= 0;
		repeat (7) @(posedge clk);
		chk(bus, 8'h3C);
		chk(data_out_oe, 8'hFF);
	endtask : s_all
	task automatic tally_and_finish();
		$display("%0d errors %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (4) @(posedge clk);
		reset <= 0;
		s_all();
		tally_and_finish();
	end
endmodule : tb_oer_octal_reg
